//--- verilog/fetch_seq_pkg.sv
package fetch_seq_pkg;

  // ****************************************************************
  // Widths and constants
  // ****************************************************************
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned UADDR_W    = 8;
  localparam int unsigned MODE_W     = 3;
  localparam int unsigned REGSEL_W   = 3;
  localparam logic [WORD_W-1:0]  PC_STEP      = 16'h0002;
  localparam logic [WORD_W-1:0]  WORD_RESET   = 16'h0000;
  localparam logic [MODE_W-1:0]  MODE_IDX     = 3'h6;
  localparam logic [MODE_W-1:0]  MODE_IDX_DEF = 3'h7;
  localparam logic [UADDR_W-1:0] BREAK_UADDR  = 8'h58;
  localparam int unsigned        CONSOLE_BIT  = 5;
  localparam logic [UADDR_W-1:0] UADDR_RESET  = 8'h00;
  // Instruction fields: source mode, source reg, dest mode, dest reg.
  localparam int unsigned SRC_MODE_LSB = 9;
  localparam int unsigned SRC_REG_LSB  = 6;
  localparam int unsigned DST_MODE_LSB = 3;
  localparam int unsigned DST_REG_LSB  = 0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH_START,
    ST_FETCH_COMPLETE,
    ST_DECODE,
    ST_AFTER_DECODE,
    ST_EXECUTE,
    ST_BREAK
  } seq_state_t;

  // Bus request toward external storage.
  typedef struct packed {
    logic              read;
    logic              bus_end_op;
    logic [WORD_W-1:0] addr;
  } bus_req_t;

  // Bus answer from external storage.
  typedef struct packed {
    logic              done;
    logic [WORD_W-1:0] data;
  } bus_rsp_t;

endpackage

//--- verilog/instruction_fetch_sequencer.sv
`timescale 1ns/1ns
// Overview of operation
// [RULE_01] Fetch takes complete state then decode state.
// [RULE_02] Overlapped fetch completes the read started earlier.
// [RULE_03] Fetched word loads instruction and buffer registers.
// [RULE_04] Program counter advances by two during completion.
// [RULE_05] No earlier read inserts a fetch start state.
// [RULE_06] Fetch start tests pending asynchronous work.
// [RULE_07] Pending work branches to the break state.
// [RULE_08] Overlapped read start does the same test.
// [RULE_09] Decode starts read of the following word.
// [RULE_10] Following read kept for modes six, seven, simple.
// [RULE_11] Otherwise next state aborts with bus end.
// [RULE_12] Next state loads source and destination work registers.
// [RULE_13] Break address modified: console flag sets bit five.
module instruction_fetch_sequencer
  import fetch_seq_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  input  wire logic                ce_i,
  input  wire logic                start_i,
  input  wire logic                pending_req_i,
  input  wire logic                console_flag_i,
  input  wire logic                no_transfer_instr_i,
  input  wire logic                exec_done_i,
  input  wire logic                overlap_i,
  input  wire logic [WORD_W-1:0]   gpr_src_i,
  input  wire logic [WORD_W-1:0]   gpr_dst_i,
  input  wire bus_rsp_t            bus_rsp_i,
  output bus_req_t                 bus_req_o,
  output logic [WORD_W-1:0]        instruction_reg_o,
  output logic [WORD_W-1:0]        bus_buffer_reg_o,
  output logic [WORD_W-1:0]        pc_o,
  output logic [WORD_W-1:0]        source_work_reg_o,
  output logic [WORD_W-1:0]        dest_work_reg_o,
  output logic [REGSEL_W-1:0]      src_sel_o,
  output logic [REGSEL_W-1:0]      dst_sel_o,
  output logic [UADDR_W-1:0]       uaddr_o,
  output logic [2:0]               state_o,
  output logic                     break_o
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Modes that consume the word after the instruction.
  function automatic logic uses_next_word(input logic [MODE_W-1:0] m);
    uses_next_word = (m == MODE_IDX) || (m == MODE_IDX_DEF);
  endfunction

  function automatic logic [MODE_W-1:0] mode_of(input logic [WORD_W-1:0] w,
                                                input int unsigned lsb);
    mode_of = w[lsb +: MODE_W];
  endfunction

  seq_state_t        state;
  seq_state_t        next_state;
  logic              read_open;
  logic              keep_spec;
  logic              exec_overlap;

  // Speculative read survives if either operand uses modes 6 or 7.
  assign keep_spec = uses_next_word(mode_of(instruction_reg_o, SRC_MODE_LSB))
                   | uses_next_word(mode_of(instruction_reg_o, DST_MODE_LSB))
                   | no_transfer_instr_i; // RULE_10

  // An overlapped exit is taken only when the read start is not blocked.
  assign exec_overlap = overlap_i & ~pending_req_i; // RULE_08

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Successor selection, including the pending-work branches.
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start_i) begin
          next_state = ST_FETCH_START;
        end
      end
      ST_FETCH_START: begin
        if (pending_req_i) begin
          next_state = ST_BREAK; // RULE_06 RULE_07
        end else begin
          next_state = ST_FETCH_COMPLETE; // RULE_05
        end
      end
      ST_FETCH_COMPLETE: begin
        if (bus_rsp_i.done) begin
          next_state = ST_DECODE; // RULE_01
        end
      end
      ST_DECODE: begin
        next_state = ST_AFTER_DECODE;
      end
      ST_AFTER_DECODE: begin
        next_state = ST_EXECUTE;
      end
      ST_EXECUTE: begin
        if (exec_done_i) begin
          if (pending_req_i && overlap_i) begin
            next_state = ST_BREAK; // RULE_08
          end else if (exec_overlap) begin
            next_state = ST_FETCH_COMPLETE; // RULE_02
          end else begin
            next_state = ST_FETCH_START; // RULE_05
          end
        end
      end
      ST_BREAK: begin
        next_state = ST_FETCH_START;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // State register; the clock enable freezes all sequencing.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
    end else if (ce_i) begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Bus requests
  // ****************************************************************

  // The read strobe is held while a read is open; the bus end pulse
  // drops it, so storage must treat an abort as ending the cycle.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      bus_req_o <= '0;
      read_open <= 1'b0;
    end else if (ce_i) begin
      bus_req_o.bus_end_op <= 1'b0;
      if (state == ST_FETCH_START && !pending_req_i) begin
        bus_req_o.read <= 1'b1; // RULE_05
        bus_req_o.addr <= pc_o;
        read_open      <= 1'b1;
      end else if (state == ST_EXECUTE && exec_done_i && exec_overlap) begin
        bus_req_o.read <= 1'b1; // RULE_08
        bus_req_o.addr <= pc_o;
        read_open      <= 1'b1;
      end else if (state == ST_FETCH_COMPLETE && bus_rsp_i.done) begin
        bus_req_o.read <= 1'b0;
        read_open      <= 1'b0;
      end else if (state == ST_DECODE) begin
        bus_req_o.read <= 1'b1; // RULE_09
        bus_req_o.addr <= pc_o;
        read_open      <= 1'b1;
      end else if (state == ST_AFTER_DECODE && !keep_spec && read_open) begin
        bus_req_o.read       <= 1'b0;
        bus_req_o.bus_end_op <= 1'b1; // RULE_11
        read_open            <= 1'b0;
      end else if (state == ST_EXECUTE && bus_rsp_i.done) begin
        bus_req_o.read <= 1'b0;
        read_open      <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Data registers
  // ****************************************************************

  // Completion loads both registers and steps the program counter.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      instruction_reg_o <= WORD_RESET;
      bus_buffer_reg_o  <= WORD_RESET;
      pc_o              <= WORD_RESET;
    end else if (ce_i) begin
      if (state == ST_FETCH_COMPLETE && bus_rsp_i.done) begin
        instruction_reg_o <= bus_rsp_i.data; // RULE_03
        bus_buffer_reg_o  <= bus_rsp_i.data; // RULE_03
        pc_o              <= pc_o + PC_STEP; // RULE_04
      end
    end
  end

  // Work registers load from the selected general registers.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      source_work_reg_o <= WORD_RESET;
      dest_work_reg_o   <= WORD_RESET;
    end else if (ce_i && state == ST_AFTER_DECODE) begin
      source_work_reg_o <= gpr_src_i; // RULE_12
      dest_work_reg_o   <= gpr_dst_i; // RULE_12
    end
  end

  // Register selects are decoded straight from the instruction.
  assign src_sel_o = instruction_reg_o[SRC_REG_LSB +: REGSEL_W];
  assign dst_sel_o = instruction_reg_o[DST_REG_LSB +: REGSEL_W];

  // ****************************************************************
  // Break microword address
  // ****************************************************************

  // A set console flag modifies bit 5 of the stored break address.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      uaddr_o <= UADDR_RESET;
      break_o <= 1'b0;
    end else if (ce_i) begin
      break_o <= (state == ST_BREAK);
      if (state == ST_BREAK) begin
        uaddr_o <= BREAK_UADDR;
        uaddr_o[CONSOLE_BIT] <= console_flag_i; // RULE_13
      end
    end
  end

  assign state_o = state;

endmodule

//--- tb/fetch_mem_model.sv
`timescale 1ns/1ns
// Storage behind the processor bus; answers each read after lat_i waiting cycles.
module fetch_mem_model
  import fetch_seq_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              sys_rst_i,
  input  wire bus_req_t          req_i,
  input  wire logic [WORD_W-1:0] word_i,
  input  wire logic [1:0]        lat_i,
  output bus_rsp_t               rsp_o
);
  logic [1:0] cnt;
  // Idle data toggles every cycle, so a stale word never passes for an answer.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !req_i.read || rsp_o.done) begin
      cnt        <= 2'h0;
      rsp_o.done <= 1'b0;
      rsp_o.data <= sys_rst_i ? WORD_RESET : ~rsp_o.data;
    end else if (cnt >= lat_i) begin
      rsp_o <= '{done: 1'b1, data: word_i};
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule

//--- tb/fetch_seq_asserts.sv
`timescale 1ns/1ns
module fetch_seq_asserts
  import fetch_seq_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               sys_rst_i,
  input wire logic               ce_i,
  input wire logic               pending_req_i,
  input wire logic               console_flag_i,
  input wire logic               no_transfer_instr_i,
  input wire logic               exec_done_i,
  input wire logic               overlap_i,
  input wire logic [WORD_W-1:0]  gpr_src_i,
  input wire logic [WORD_W-1:0]  gpr_dst_i,
  input wire bus_rsp_t           bus_rsp_i,
  input wire bus_req_t           bus_req_o,
  input wire logic [WORD_W-1:0]  instruction_reg_o,
  input wire logic [WORD_W-1:0]  bus_buffer_reg_o,
  input wire logic [WORD_W-1:0]  pc_o,
  input wire logic [WORD_W-1:0]  source_work_reg_o,
  input wire logic [WORD_W-1:0]  dest_work_reg_o,
  input wire logic [UADDR_W-1:0] uaddr_o,
  input wire logic [2:0]         state_o,
  input wire logic               break_o
);
  // ****************************
  // Sequencing checks
  // ****************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic keep;
  // Modes 6 and 7 are the only ones with both high bits set.
  assign keep = no_transfer_instr_i || (&instruction_reg_o[SRC_MODE_LSB+1 +: 2])
                || (&instruction_reg_o[DST_MODE_LSB+1 +: 2]);
  sequence s_done; ce_i && state_o == ST_FETCH_COMPLETE && bus_rsp_i.done; endsequence
  sequence s_fstart; ce_i && state_o == ST_FETCH_START; endsequence
  AST_FCOMP_DECODE: assert property (s_done |=> state_o == ST_DECODE)
    else $error("no decode after fetch");
  AST_LOAD_IR: assert property (s_done |=> instruction_reg_o == $past(bus_rsp_i.data)
    && bus_buffer_reg_o == $past(bus_rsp_i.data)) else $error("word not loaded");
  AST_PC_STEP: assert property (s_done |=> pc_o == $past(pc_o) + PC_STEP)
    else $error("pc step");
  AST_START_READ: assert property (s_fstart ##0 !pending_req_i |=>
    state_o == ST_FETCH_COMPLETE && bus_req_o.read && bus_req_o.addr == pc_o) else $error("no read");
  AST_START_BRK: assert property (s_fstart ##0 pending_req_i |=>
    state_o == ST_BREAK && !bus_req_o.read) else $error("no break");
  AST_OVERLAP: assert property (ce_i && state_o == ST_EXECUTE && exec_done_i && overlap_i |=>
    bus_req_o.read != $past(pending_req_i)) else $error("overlap read");
  AST_DECODE_READ: assert property (ce_i && state_o == ST_DECODE |=>
    bus_req_o.read && bus_req_o.addr == pc_o) else $error("no next word read");
  AST_ABORT: assert property (ce_i && state_o == ST_AFTER_DECODE |=>
    bus_req_o.bus_end_op != $past(keep)) else $error("abort choice");
  AST_END_PULSE: assert property ($rose(bus_req_o.bus_end_op) |->
    !bus_req_o.read ##1 !bus_req_o.bus_end_op) else $error("bus end pulse");
  AST_WORK_REGS: assert property (ce_i && state_o == ST_AFTER_DECODE |=>
    source_work_reg_o == $past(gpr_src_i) && dest_work_reg_o == $past(gpr_dst_i))
    else $error("work reg");
  AST_BREAK_ADDR: assert property (ce_i && state_o == ST_BREAK |=> break_o
    && uaddr_o == (BREAK_UADDR | ($past(console_flag_i) << CONSOLE_BIT))) else $error("uaddr");
endmodule
bind instruction_fetch_sequencer fetch_seq_asserts chk (.*);

//--- tb/tb_instruction_fetch_sequencer.sv
`timescale 1ns/1ns
module tb_instruction_fetch_sequencer
  import fetch_seq_pkg::*;
;
  logic               clk_i = 1'b0, rst = 1'b1, go = 1'b0, pend = 1'b0, cf = 1'b0;
  logic               nt = 1'b0, xd = 1'b0, ov = 1'b0, brk, ce = 1'b1;
  logic [REGSEL_W-1:0] ss, ds;
  logic [WORD_W-1:0]  gs = '0, gd = '0, w = '0, pc0, ir, br, pc, swr, dwr;
  logic [1:0]         lat = '0;
  logic [UADDR_W-1:0] ua;
  logic [2:0]         st;
  bus_req_t           req;
  bus_rsp_t           rsp;
  int                 fails = 0, checked = 0, seed = 97727, r;
  logic [WORD_W-1:0]  corner [4] = '{16'h0c00, 16'h0038, 16'h0000, 16'h0e3f};
  always #5 clk_i = ~clk_i;
  instruction_fetch_sequencer dut (.clk_i, .sys_rst_i(rst), .ce_i(ce), .start_i(go),
    .pending_req_i(pend), .console_flag_i(cf), .no_transfer_instr_i(nt), .exec_done_i(xd),
    .overlap_i(ov), .gpr_src_i(gs), .gpr_dst_i(gd), .bus_rsp_i(rsp), .bus_req_o(req),
    .instruction_reg_o(ir), .bus_buffer_reg_o(br), .pc_o(pc), .source_work_reg_o(swr),
    .dest_work_reg_o(dwr), .src_sel_o(ss), .dst_sel_o(ds), .uaddr_o(ua), .state_o(st),
    .break_o(brk));
  fetch_mem_model mem (.clk_i, .sys_rst_i(rst), .req_i(req), .word_i(w), .lat_i(lat),
    .rsp_o(rsp));
  // ****************************
  // Helpers
  // ****************************
  task automatic chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task step; @(posedge clk_i); #1; endtask
  // Bounded so a stuck sequencer fails the next compare instead of hanging.
  task automatic wait_st(input logic [2:0] s);
    for (int n = 0; n < 20 && st !== s && st !== ST_BREAK; n++) step;
  endtask
  function automatic logic abort_of(logic [WORD_W-1:0] v, logic n);
    return !(n || (&v[SRC_MODE_LSB+1 +: 2]) || (&v[DST_MODE_LSB+1 +: 2]));
  endfunction
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Random instructions, corner words first, with breaks and overlap mixed in.
  initial begin
    repeat (5) step;
    rst = 1'b0;
    go = 1'b1;
    for (int i = 0; i < 60; i++) begin
      w = (i < 4) ? corner[i] : WORD_W'($random(seed));
      {gs, gd} = $random(seed);
      r = $random(seed);
      {nt, cf, lat} = r[3:0];
      wait_st(ST_FETCH_COMPLETE);
      if (st === ST_BREAK) begin
        step;
        chk(brk, 1'b1);
        chk(ua, BREAK_UADDR | (cf << CONSOLE_BIT));
        pend = 1'b0;
        wait_st(ST_FETCH_COMPLETE);
      end
      pc0 = pc;
      wait_st(ST_DECODE);
      chk(ir, w);
      chk(br, w);
      chk(pc, pc0 + PC_STEP);
      chk(ss, w[SRC_REG_LSB +: REGSEL_W]);
      chk(ds, w[DST_REG_LSB +: REGSEL_W]);
      // Some passes hold the enable low in decode, where no read is open, so nothing may move.
      if (i % 8 == 3) begin
        ce = 1'b0;
        repeat (3) step;
        chk(st, ST_DECODE);
        chk(pc, pc0 + PC_STEP);
        chk(req.read, 1'b0);
        ce = 1'b1;
      end
      step;
      chk(req.addr, pc);
      step;
      chk(req.bus_end_op, abort_of(w, nt));
      chk(req.read, !abort_of(w, nt));
      chk(swr, gs);
      chk(dwr, gd);
      r = $random(seed);
      {pend, ov} = {r[1:0] == 2'h0, r[2]};
      repeat (4) step;
      xd = 1'b1;
      step;
      xd = 1'b0;
      chk(st, !ov ? ST_FETCH_START : pend ? ST_BREAK : ST_FETCH_COMPLETE);
    end
    give_verdict;
  end
  // Watchdog well beyond the roughly 1000 cycles the sequence needs.
  initial begin
    #100000;
    fails++;
    give_verdict;
  end
endmodule
